/* hdl/nps_consts.svh */
/*
 * nps_consts.svh: offsets, field positions, reset values and counts
 * for the phase source and input register block.
 * Assumes inclusion by bare name from any design file that needs them.
 */
`ifndef NPS_CONSTS_SVH
`define NPS_CONSTS_SVH

// register byte addresses on the apb slave
`define NPS_ADDR_CTRL 8'h00
`define NPS_ADDR_PHASE_CTRL 8'h04
`define NPS_ADDR_FREQ 8'h08
`define NPS_ADDR_TIMER_INC 8'h0C
`define NPS_ADDR_STATUS 8'h10
`define NPS_ADDR_FIFO_DATA 8'h14
`define NPS_ADDR_SINCOS 8'h18
`define NPS_ADDR_PHASE_ACC 8'h1C

// control register fields and reset values
`define NPS_CTRL_RUN 0
`define NPS_CTRL_CAPTURE 1
`define NPS_CTRL_RESET 32'h0000_0003
`define NPS_WORD_RESET 32'h0000_0000

// status register fields
`define NPS_STAT_LEVEL_LSB 0
`define NPS_STAT_PEND 8
`define NPS_STAT_SOURCE 9
`define NPS_STAT_BYPASS 10

// phase word layout and data widths
`define NPS_PHASE_LOW_BITS 14
`define NPS_WINDOW_BITS 16
`define NPS_INPUT_BITS 19

// fifo depth and synchroniser length
`define NPS_FIFO_DEPTH 32
`define NPS_SYNC_STAGES 3

`endif

/* hdl/nps_pkg.sv */
/*
 * nps_pkg: types shared by the phase source and input register block.
 * Assumes nps_consts.svh is compiled alongside.
 */
package nps_pkg;

	// pin inputs as one vector, so one synchroniser carries them all
	typedef struct packed {
		logic phase_source_select;
		logic [1:0] phase_offset_bits;
		logic rom_bypass_timer_load_n;
		logic phase_carry_in_n;
		logic input_register_enable_n;
		logic [1:0] input_shift_select;
		logic [18:0] real_input_bus;
		logic [18:0] imag_input_bus;
	} nps_pins_t;

	// whole state of the top module
	typedef struct packed {
		logic [31:0] ctrl;
		logic [15:0] phase_ctrl;
		logic [31:0] freq;
		logic [31:0] timer_inc;
		logic [15:0] phase_reg;
		logic [31:0] phase_acc;
		logic [31:0] timer_acc;
		logic [18:0] real_reg;
		logic [18:0] imag_reg;
		logic push_pend;
		logic phase_carry_n;
		logic interval_carry_n;
		logic [15:0] sine;
		logic [15:0] cosine;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} nps_top_state_t;

endpackage : nps_pkg

/* hdl/nps_fifo_if.sv */
/*
 * nps_fifo_if: valid/ready carrier between the top and its fifo.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface nps_fifo_if #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) ();
	logic push_valid;
	logic push_ready;
	logic [WIDTH-1:0] push_data;
	logic pop_valid;
	logic pop_ready;
	logic [WIDTH-1:0] pop_data;
	logic [$clog2(DEPTH):0] level;

	modport fifo (input push_valid, push_data, pop_ready,
		output push_ready, pop_valid, pop_data, level);
	modport user (output push_valid, push_data, pop_ready,
		input push_ready, pop_valid, pop_data, level);
endinterface : nps_fifo_if

/* hdl/nps_sync.sv */
/*
 * nps_sync: three-stage synchroniser for a vector of pin inputs.
 * Assumes inputs are asynchronous to pclk; a bit changes at the output
 * only once stages two and three agree on it.
 */
`timescale 1ns/1ns
module nps_sync #(
	parameter int WIDTH = 8,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// pins in, settled copy out
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} nps_sync_state_t;

	nps_sync_state_t s;
	nps_sync_state_t next_s;

	// s1 feeds s2 only; the agreement test looks at s2 and s3
	always_comb begin
		next_s = s;
		next_s.s1 = d;
		next_s.s2 = s.s1;
		next_s.s3 = s.s2;
		next_s.q = (s.s2 & ~(s.s2 ^ s.s3)) | (s.q & (s.s2 ^ s.s3));
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= {IDLE, IDLE, IDLE, IDLE};
		end else begin
			s <= next_s;
		end
	end

	assign q = s.q;
endmodule : nps_sync

/* hdl/nps_fifo.sv */
/*
 * nps_fifo: synchronous flip-flop fifo with valid/ready on both sides.
 * Assumes DEPTH is a power of two; push and pop may share a cycle.
 */
`timescale 1ns/1ns
module nps_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// both sides of the buffer
	nps_fifo_if.fifo f
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr;
		logic [AW-1:0] rd;
		logic [AW:0] count;
	} nps_fifo_state_t;

	nps_fifo_state_t s;
	nps_fifo_state_t next_s;
	logic do_push;
	logic do_pop;

	// full and empty come straight from the count
	assign f.push_ready = (s.count != (AW+1)'(DEPTH));
	assign f.pop_valid = (s.count != '0);
	assign f.pop_data = s.mem[s.rd];
	assign f.level = s.count;
	assign do_push = f.push_valid & f.push_ready;
	assign do_pop = f.pop_ready & f.pop_valid;

	always_comb begin
		next_s = s;
		if (do_push) begin
			next_s.mem[s.wr] = f.push_data;
			next_s.wr = s.wr + 1'b1;
		end
		if (do_pop) begin
			next_s.rd = s.rd + 1'b1;
		end
		next_s.count = s.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule : nps_fifo

/* hdl/nps_top.sv */
/*
 * nps_top: phase source select, rom bypass and timer load, carry
 * outputs, and the complex input registers with window selection.
 * Assumes an apb master on pclk and host pins asynchronous to pclk;
 * captured sample windows queue in a fifo that software drains.
 */
`timescale 1ns/1ns
`include "nps_consts.svh"

// Contract
// - select high loads phase from control register
// - select low loads offset bits, low zeros
// - offset codes map to 0/90/270/180 degrees
// - bypass routes adder and accumulator to multiplier
// - bypass zeros timer feedback, loading increment
// - active-low registered carry on phase overflow
// - real bus captured while enable asserted; here not while a pair is pending, so every other cycle at most
// - imaginary bus captured while enable asserted; here not while a pair is pending, so every other cycle at most
// - enable is active low and registered first
// - shift code zero selects bits 0-15
module nps_top (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// phase control pins
	input wire logic phase_source_select,
	input wire logic [1:0] phase_offset_bits,
	input wire logic rom_bypass_timer_load_n,
	input wire logic phase_carry_in_n,
	// input data pins
	input wire logic input_register_enable_n,
	input wire logic [1:0] input_shift_select,
	input wire logic [18:0] real_input_bus,
	input wire logic [18:0] imag_input_bus,
	// carry outputs
	output logic phase_carry_out_n,
	output logic interval_carry_out_n,
	// vector fed to the multiplier
	output logic [15:0] sine_out,
	output logic [15:0] cosine_out
);
	localparam int PW = $bits(nps_pkg::nps_pins_t);
	localparam int LW = $clog2(`NPS_FIFO_DEPTH) + 1;

	// idle level of the pins: active-low strobes released
	localparam nps_pkg::nps_pins_t PINS_IDLE = '{
		phase_source_select: 1'b1,
		phase_offset_bits: 2'h0,
		rom_bypass_timer_load_n: 1'b1,
		phase_carry_in_n: 1'b1,
		input_register_enable_n: 1'b1,
		input_shift_select: 2'h0,
		real_input_bus: 19'h0_0000,
		imag_input_bus: 19'h0_0000
	};

	nps_pkg::nps_top_state_t s;
	nps_pkg::nps_top_state_t next_s;
	nps_pkg::nps_pins_t pins_raw;
	nps_pkg::nps_pins_t pins;
	logic [PW-1:0] pins_q;

	// offset code to the top two phase bits; codes 10 and 11 swap
	function automatic logic [1:0] offset_to_phase(input logic [1:0] code);
		offset_to_phase = {code[1], code[1] ^ code[0]};
	endfunction : offset_to_phase

	// 16-bit window of a 19-bit bus, moved up by the shift code
	function automatic logic [15:0] window(input logic [18:0] bus,
		input logic [1:0] sh);
		logic [18:0] shifted;
		shifted = bus >> sh;
		window = shifted[15:0];
	endfunction : window

	// coarse triangle stand-in for the sine table, quarter-wave folded
	function automatic logic [15:0] tri_wave(input logic [15:0] ph);
		logic [15:0] mag;
		mag = ph[14] ? {1'b0, ~ph[13:0], 1'b0} : {1'b0, ph[13:0], 1'b0};
		tri_wave = ph[15] ? 16'(-mag) : mag;
	endfunction : tri_wave

	// every pin passes the three-stage synchroniser
	assign pins_raw = '{
		phase_source_select: phase_source_select,
		phase_offset_bits: phase_offset_bits,
		rom_bypass_timer_load_n: rom_bypass_timer_load_n,
		phase_carry_in_n: phase_carry_in_n,
		input_register_enable_n: input_register_enable_n,
		input_shift_select: input_shift_select,
		real_input_bus: real_input_bus,
		imag_input_bus: imag_input_bus
	};

	nps_sync #(
		.WIDTH(PW),
		.IDLE(PINS_IDLE)
	) u_sync (
		.pclk(pclk),
		.presetn(presetn),
		.d(pins_raw),
		.q(pins_q)
	);

	assign pins = nps_pkg::nps_pins_t'(pins_q);

	nps_fifo_if #(
		.WIDTH(32),
		.DEPTH(`NPS_FIFO_DEPTH)
	) fq ();

	nps_fifo #(
		.WIDTH(32),
		.DEPTH(`NPS_FIFO_DEPTH)
	) u_fifo (
		.pclk(pclk),
		.presetn(presetn),
		.f(fq.fifo)
	);

	// a captured pair waits in push_pend until the fifo takes it
	assign fq.push_valid = s.push_pend;
	assign fq.push_data = {window(s.imag_reg, pins.input_shift_select),
		window(s.real_reg, pins.input_shift_select)};

	// apb access phase, first cycle only; the slave answers one cycle later
	logic access;
	logic rd_data;
	assign access = psel & penable & ~s.pready;
	assign rd_data = access & ~pwrite & (paddr == `NPS_ADDR_FIFO_DATA);
	assign fq.pop_ready = rd_data;

	logic run;
	logic capture_on;
	logic bypass;
	logic [15:0] phase_sum;
	logic [32:0] phase_next;
	logic [32:0] timer_next;
	logic [31:0] timer_feedback;
	logic [32:0] carry_in;
	logic [31:0] status;
	logic take;

	always_comb begin
		run = s.ctrl[`NPS_CTRL_RUN];
		capture_on = s.ctrl[`NPS_CTRL_CAPTURE];
		bypass = ~pins.rom_bypass_timer_load_n;
		phase_sum = s.phase_acc[31:16] + s.phase_reg;
		carry_in = {32'h0000_0000, ~pins.phase_carry_in_n};
		phase_next = {1'b0, s.phase_acc} + {1'b0, s.freq} + carry_in;
		timer_feedback = bypass ? `NPS_WORD_RESET : s.timer_acc;
		timer_next = {1'b0, timer_feedback} + {1'b0, s.timer_inc};
		// stall capture while the previous pair has not been pushed
		take = ~pins.input_register_enable_n & capture_on & ~s.push_pend;
		status = `NPS_WORD_RESET;
		status[`NPS_STAT_LEVEL_LSB +: LW] = fq.level;
		status[`NPS_STAT_PEND] = s.push_pend;
		status[`NPS_STAT_SOURCE] = pins.phase_source_select;
		status[`NPS_STAT_BYPASS] = bypass;
	end

	// phase, timer and multiplier vector
	always_comb begin
		next_s = s;
		if (pins.phase_source_select) begin
			next_s.phase_reg = s.phase_ctrl;
		end else begin
			next_s.phase_reg = {offset_to_phase(pins.phase_offset_bits),
				`NPS_PHASE_LOW_BITS'(0)};
		end
		next_s.phase_carry_n = 1'b1;
		next_s.interval_carry_n = 1'b1;
		if (run) begin
			next_s.phase_acc = phase_next[31:0];
			next_s.phase_carry_n = ~phase_next[32];
		end
		// bypass loads the timer even when accumulation is stopped
		if (run | bypass) begin
			next_s.timer_acc = timer_next[31:0];
			next_s.interval_carry_n = ~timer_next[32];
		end
		if (bypass) begin
			next_s.sine = phase_sum;
			next_s.cosine = s.phase_acc[15:0];
		end else begin
			next_s.sine = tri_wave(phase_sum);
			next_s.cosine = tri_wave(phase_sum + 16'h4000);
		end

		// input registers and the hand-off to the fifo
		if (fq.push_ready) begin
			next_s.push_pend = 1'b0;
		end
		if (take) begin
			next_s.real_reg = pins.real_input_bus;
			next_s.imag_reg = pins.imag_input_bus;
			next_s.push_pend = 1'b1;
		end

		// apb answer: ready for one cycle after the first access cycle
		next_s.pready = access;
		next_s.pslverr = 1'b0;
		if (access) begin
			next_s.prdata = `NPS_WORD_RESET;
			case (paddr)
				`NPS_ADDR_CTRL: begin
					if (pwrite) begin
						next_s.ctrl = pwdata & `NPS_CTRL_RESET;
					end
					next_s.prdata = s.ctrl;
				end
				`NPS_ADDR_PHASE_CTRL: begin
					if (pwrite) begin
						next_s.phase_ctrl = pwdata[15:0];
					end
					next_s.prdata = {16'h0000, s.phase_ctrl};
				end
				`NPS_ADDR_FREQ: begin
					if (pwrite) begin
						next_s.freq = pwdata;
					end
					next_s.prdata = s.freq;
				end
				`NPS_ADDR_TIMER_INC: begin
					if (pwrite) begin
						next_s.timer_inc = pwdata;
					end
					next_s.prdata = s.timer_inc;
				end
				`NPS_ADDR_STATUS: begin
					next_s.prdata = status;
				end
				`NPS_ADDR_FIFO_DATA: begin
					// empty fifo reads as zero and pops nothing
					next_s.prdata = fq.pop_valid ? fq.pop_data : `NPS_WORD_RESET;
				end
				`NPS_ADDR_SINCOS: begin
					next_s.prdata = {s.sine, s.cosine};
				end
				`NPS_ADDR_PHASE_ACC: begin
					next_s.prdata = s.phase_acc;
				end
				default: begin
					next_s.pslverr = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s <= '0;
			s.ctrl <= `NPS_CTRL_RESET;
			s.phase_carry_n <= 1'b1;
			s.interval_carry_n <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// every output straight from the state register
	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign phase_carry_out_n = s.phase_carry_n;
	assign interval_carry_out_n = s.interval_carry_n;
	assign sine_out = s.sine;
	assign cosine_out = s.cosine;
endmodule : nps_top

/* tb/nps_top_checker.sv */
/* nps_top_checker: apb answer timing and error checks on nps_top ports.
 * Assumes one clock and the async active-low reset. */
`timescale 1ns/1ns
module nps_top_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// past the last mapped word
	logic hole;
	assign hole = paddr > 8'h1C;
	// first access cycle of a transfer
	sequence s_acc;
		psel && penable && !pready;
	endsequence
	a_ready_wait: assert property (s_acc |=> pready) else $error("no answer");
	a_ready_once: assert property (pready |=> !pready) else $error("long ready");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("ready unasked");
	a_setup_quiet: assert property (psel && !penable |-> !pready) else $error("early ready");
	a_err_ready: assert property (pslverr |-> pready) else $error("lone error");
	a_err_zero: assert property (pslverr |-> prdata == 32'h0000_0000)
		else $error("error data");
	a_hole_err: assert property ((s_acc ##0 hole) |=> pslverr) else $error("hole ok");
	a_map_ok: assert property ((s_acc ##0 (!hole && paddr[1:0] == 2'b00)) |=> !pslverr)
		else $error("mapped error");
endmodule : nps_top_checker

bind nps_top nps_top_checker u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));

/* tb/nps_host.sv */
/* nps_host: host driving phase pins and sample buses.
 * Assumes calls come from one process; pins change after an edge. */
`timescale 1ns/1ns
module nps_host (
	// clock
	input wire logic pclk,
	// phase pins
	output logic phase_source_select,
	output logic [1:0] phase_offset_bits,
	output logic rom_bypass_timer_load_n,
	output logic phase_carry_in_n,
	// data pins
	output logic input_register_enable_n,
	output logic [1:0] input_shift_select,
	output logic [18:0] real_input_bus,
	output logic [18:0] imag_input_bus
);
	// idle: active-low lines released, select high
	initial begin
		phase_source_select = 1'b1;
		phase_offset_bits = 2'b00;
		rom_bypass_timer_load_n = 1'b1;
		phase_carry_in_n = 1'b1;
		input_register_enable_n = 1'b1;
		input_shift_select = 2'b00;
		real_input_bus = 19'h0_0000;
		imag_input_bus = 19'h0_0000;
	end
	// phase controls
	task automatic phase(input logic s, input logic [1:0] c, input logic b);
		@(posedge pclk);
		phase_source_select <= s;
		phase_offset_bits <= c;
		rom_bypass_timer_load_n <= b;
	endtask : phase
	// two's complement samples, enable active low
	task automatic data(input logic e, input logic [1:0] h, input logic [18:0] r, i);
		@(posedge pclk);
		input_register_enable_n <= e;
		input_shift_select <= h;
		real_input_bus <= r;
		imag_input_bus <= i;
	endtask : data
endmodule : nps_host

/* tb/test_nps_top.sv */
/* test_nps_top: self-checking bench for nps_top with a queue model.
 * Assumes nps_host drives the pins and apb comes from this module. */
`timescale 1ns/1ns
module test_nps_top;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd, v;
	logic sel, byp, pci, en, pco, ico;
	logic [1:0] off, sh;
	logic [18:0] rin, iin, r, i;
	logic [15:0] sin, cos;
	int fails, comparisons, seed, n, p, t;
	logic [31:0] q[$];

	nps_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .phase_source_select(sel), .phase_offset_bits(off),
		.rom_bypass_timer_load_n(byp), .phase_carry_in_n(pci),
		.input_register_enable_n(en), .input_shift_select(sh), .real_input_bus(rin),
		.imag_input_bus(iin), .phase_carry_out_n(pco), .interval_carry_out_n(ico),
		.sine_out(sin), .cosine_out(cos));
	nps_host u_host (.pclk(pclk), .phase_source_select(sel), .phase_offset_bits(off),
		.rom_bypass_timer_load_n(byp), .phase_carry_in_n(pci),
		.input_register_enable_n(en), .input_shift_select(sh), .real_input_bus(rin),
		.imag_input_bus(iin));

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// cut a hang short
	initial begin
		#200000;
		fails++;
		give_verdict;
	end

	task chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// one apb transfer; waits for pready however long it takes
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	function automatic logic [1:0] mapc(input int c);
		return c == 2 ? 2'b11 : c == 3 ? 2'b10 : c[1:0];
	endfunction : mapc
	// counts active-low carry pulses over k edges
	task cnt(input int k);
		p = 0;
		t = 0;
		repeat (k) begin
			@(posedge pclk);
			p += (pco === 1'b0);
			t += (ico === 1'b0);
		end
	endtask : cnt
	// pops the fifo against the model queue
	task drain;
		while (q.size() > 0) begin
			apb(1'b0, 8'h14, 32'h0000_0000);
			chk(rd, q.pop_front());
		end
	endtask : drain
	task push(input int k, input logic [1:0] h);
		repeat (k) q.push_back({16'(i >> h), 16'(r >> h)});
	endtask : push
	task give_verdict;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : give_verdict

	initial begin
		seed = 45812;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk(rd, 32'h0000_0003);
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(er, 1'b1);
		$display("test regs done");
		// bypass on, run off: sine shows the phase register alone
		apb(1'b1, 8'h00, 32'h0000_0000);
		for (int c = 0; c < 4; c++) begin
			u_host.phase(1'b0, c[1:0], 1'b0);
			repeat (12) @(posedge pclk);
			chk(sin, {mapc(c), 14'h0000});
			chk(cos, 32'h0000_0000);
		end
		v = $random(seed);
		apb(1'b1, 8'h04, v);
		u_host.phase(1'b1, 2'b00, 1'b0);
		repeat (12) @(posedge pclk);
		chk(sin, v[15:0]);
		$display("test phase done");
		// half-turn phase step, quarter-turn timer step
		apb(1'b1, 8'h08, 32'h8000_0000);
		apb(1'b1, 8'h0C, 32'h4000_0000);
		u_host.phase(1'b1, 2'b00, 1'b1);
		apb(1'b1, 8'h00, 32'h0000_0001);
		repeat (10) @(posedge pclk);
		cnt(40);
		chk(p, 20);
		chk(t, 10);
		u_host.phase(1'b1, 2'b00, 1'b0);
		repeat (10) @(posedge pclk);
		cnt(40);
		chk(t, 0);
		chk(p, 20);
		$display("test carry done");
		// capture on, run off; enable released first
		apb(1'b1, 8'h00, 32'h0000_0002);
		r = 19'($random(seed));
		i = 19'($random(seed));
		u_host.data(1'b1, 2'b00, r, i);
		repeat (12) @(posedge pclk);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(rd[5:0], 32'h0000_0000);
		for (int h = 0; h < 4; h++) begin
			r = 19'($random(seed));
			i = 19'($random(seed));
			u_host.data(1'b0, h[1:0], r, i);
			repeat (3) @(posedge pclk);
			u_host.data(1'b1, h[1:0], r, i);
			repeat (12) @(posedge pclk);
			apb(1'b0, 8'h10, 32'h0000_0000);
			n = rd[5:0];
			chk(n > 0, 1'b1);
			push(n, h[1:0]);
			drain;
		end
		// fill until full while nothing pops, then drain to empty
		u_host.data(1'b0, 2'b10, r, i);
		repeat (100) @(posedge pclk);
		u_host.data(1'b1, 2'b10, r, i);
		repeat (12) @(posedge pclk);
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk(rd[5:0], 32'h0000_0020);
		// a 33rd pair waits in the pending register and follows the first pop
		push(33, 2'b10);
		drain;
		apb(1'b0, 8'h14, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		$display("test capture done");
		give_verdict;
	end
endmodule : test_nps_top
